// [ecpp_pkg.sv]
/*
  Package of the parallel port engine: FIFO depth, entry layout, command bit, modes and timing counts.
  Assumes a single 50 MHz core_clk and synchronous active-high reset.
*/
// Function
// (RULE1) Without extended mode the port behaves as a plain legacy printer port.
// (RULE2) No negotiation; a burst channel with DMA handshake in both directions.
// (RULE3) Transfers in both directions pass through a sixteen-byte FIFO.
// (RULE4) Legacy mode strobes each byte out automatically, without software strobing.
// (RULE5) Run-length decoding is always built in hardware.
// (RULE6) A received count byte is held, and the next byte repeated count+1 times.
// (RULE7) Optional compression counts equal bytes and sends count then the byte.
// (RULE8) Forward bytes are latched on the strobe falling edge, interlocked with busy.
// (RULE9) The data lines carry address, data or run-length count bytes by phase.
// (RULE10) In reverse the peripheral answers the host acknowledge with its clock.
// (RULE11) The peripheral drops busy when it can accept another forward byte.
// (RULE12) In reverse, busy tells the host command byte or data byte.
// (RULE13) The peripheral acknowledges a direction request on the paper-error line.
// (RULE14) The host drives the data lines only after the direction acknowledge.
// (RULE15) In reverse, host acknowledge low requests a byte, interlocked with the clock.
// (RULE16) In forward, host acknowledge marks command byte versus data byte.
// (RULE17) Fault asserted raises an error event, only while going forward.
// (RULE18) Fault in extended mode is only a reverse hint; the host decides direction. Here fault_event also fires in extended forward.
// (RULE19) Init low selects reverse, init high selects forward.
// (RULE20) The peripheral reports on-line state on the select line.
// (RULE21) Every FIFO view shares the one common sixteen-byte buffer.
package ecpp_pkg;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 50;
  // Least data setup before the legacy strobe, and its least width.
  localparam int SETUP_NS = 500;
  localparam int STROBE_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 6;
  // Top bit of an extended-mode command byte: set means channel address, clear means count.
  localparam int CMD_ADDR_BIT = 7;
  // Entry layout in the common buffer: bit 8 marks a command byte.
  localparam int ENTRY_W = DATA_W + 1;
  typedef enum logic [1:0] {
    ECPP_MODE_LEGACY,
    ECPP_MODE_ECP_FWD,
    ECPP_MODE_ECP_REV
  } ecpp_mode_t;
endpackage

// [ecpp_fifo_if.sv]
/*
  Interface carrying the push and pop sides of the common buffer.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
interface ecpp_fifo_if;
  import ecpp_pkg::*;
  logic push_valid;
  logic push_ready;
  logic [ENTRY_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [ENTRY_W-1:0] pop_data;
  logic flush;
  logic full;
  logic empty;
  modport buffer (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data, full, empty);
  modport user (output push_valid, push_data, pop_ready, flush,
                input push_ready, pop_valid, pop_data, full, empty);
endinterface

// [ecpp_fifo.sv]
/*
  Common sixteen-entry buffer shared by every transfer direction.
  Assumes the user flushes it when the direction turns round.
*/
`timescale 1ns/10ps
module ecpp_fifo #(
  parameter int DEPTH = ecpp_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  ecpp_fifo_if.buffer f
);
  import ecpp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("ecpp_fifo depth must be a power of two of at least 2");
    end
  end
  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic do_push, do_pop;
  assign f.full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign f.empty = (wr_ptr == rd_ptr);
  assign f.push_ready = !f.full;
  assign f.pop_valid = !f.empty;
  assign f.pop_data = mem[rd_ptr[AW-1:0]];
  assign do_push = f.push_valid && !f.full;
  assign do_pop = f.pop_ready && !f.empty;
  // (RULE21) One buffer
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (f.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end else begin
      if (do_push) next_wr_ptr = wr_ptr + 1'b1;
      if (do_pop) next_rd_ptr = rd_ptr + 1'b1;
    end
  end
  // Storage is not reset; the pointers alone define what is valid.
  always_ff @(posedge core_clk) begin
    if (do_push && !f.flush) mem[wr_ptr[AW-1:0]] <= f.push_data;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
endmodule

// [ecpp_sync.sv]
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes the inputs are asynchronous levels.
*/
`timescale 1ns/10ps
module ecpp_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  initial begin
    if (W < 1) $error("ecpp_sync needs at least one bit");
  end
  // The first stage feeds only the second.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [ecpp_port.sv]
/*
  Host-side parallel port engine: legacy auto-strobe and extended-capability burst transfers.
  Assumes a DMA or software user on the plain side and a peripheral on the cable pins.
*/
`timescale 1ns/10ps
module ecpp_port #(
  parameter bit COMPRESS_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ecp_en,
  input wire logic dir_reverse,
  input wire logic compress,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_is_addr,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_is_cmd,
  output logic fifo_full,
  output logic fifo_empty,
  output logic dir_ack,
  output logic fault_event,
  output logic reverse_hint,
  output logic online,
  output logic dma_req,
  input wire logic pd_in,
  input wire logic [7:0] pdata_in,
  output logic [7:0] pdata_out,
  output logic pdata_oe_n,
  output logic strobe_n,
  output logic autofd_n,
  output logic init_n,
  output logic select_in_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic perror,
  input wire logic select,
  input wire logic fault_n
);
  import ecpp_pkg::*;
  typedef enum logic [2:0] {
    ECPP_IDLE, ECPP_SETUP, ECPP_STROBE, ECPP_WAIT_BUSY, ECPP_TURN, ECPP_REV_REQ, ECPP_REV_ACK
  } ecpp_state_t;
  logic s_ack_n, s_busy, s_perror, s_select, s_fault_n;
  logic [7:0] s_pdata;
  logic s_unused;
  assign s_unused = pd_in;
  ecpp_sync #(.W(5), .INIT(5'h1b)) u_sync_ctl (
    .core_clk(core_clk), .reset(reset),
    .d({ack_n, busy, perror, select, fault_n}),
    .q({s_ack_n, s_busy, s_perror, s_select, s_fault_n}));
  ecpp_sync #(.W(8), .INIT(8'h00)) u_sync_dat (
    .core_clk(core_clk), .reset(reset), .d(pdata_in), .q(s_pdata));
  ecpp_fifo_if fif ();
  ecpp_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (.core_clk(core_clk), .reset(reset), .f(fif));
  // Sequencer state, transfer timer and direction.
  ecpp_state_t state, next_state;
  logic [CNT_W-1:0] tcnt, next_tcnt;
  logic reverse, next_reverse;
  // Run-length expansion state of the reverse stream.
  logic [7:0] run_cnt, next_run_cnt;
  logic run_pend, next_run_pend;
  // Compression run: pending byte, its repeat count and whether one is held.
  logic [7:0] cmp_byte, next_cmp_byte;
  logic [7:0] cmp_cnt, next_cmp_cnt;
  logic cmp_have, next_cmp_have;
  // Registered cable outputs and the reverse holding register.
  logic [7:0] pd_reg, next_pd_reg;
  logic strobe_reg, next_strobe_reg;
  logic afd_reg, next_afd_reg;
  logic [7:0] rx_reg, next_rx_reg;
  logic rx_cmd_reg, next_rx_cmd_reg;
  logic rx_full, next_rx_full;
  logic fault_d, want_rev, push_cnt, rev_take;
  // A count that does not fit the timer would wrap and cut the setup or strobe short.
  initial begin
    if (SETUP_CYC >= (1 << CNT_W) || STROBE_CYC >= (1 << CNT_W)) begin
      $error("ecpp_port timing counts exceed the timer width");
    end
  end
  // (RULE15) A reverse byte is taken once, on the edge that leaves the request state.
  assign rev_take = (state == ECPP_REV_REQ) && (want_rev == reverse) && !s_ack_n && fif.push_ready;
  // (RULE19) Direction select
  assign want_rev = ecp_en && dir_reverse;
  assign init_n = !reverse;
  assign select_in_n = 1'b0;
  // (RULE20) On-line status
  assign online = s_select;
  // (RULE13) Direction acknowledge
  assign dir_ack = reverse ? !s_perror : s_perror;
  // (RULE18) Reverse hint only
  assign reverse_hint = ecp_en && !s_fault_n && !reverse;
  assign fifo_full = fif.full;
  assign fifo_empty = fif.empty;
  // (RULE2) DMA request level
  assign dma_req = reverse ? fif.pop_valid : fif.push_ready;
  // Compressor emits a count byte when a run ends; it stalls the source meanwhile.
  assign push_cnt = COMPRESS_EN && compress && ecp_en && cmp_have &&
                    (cmp_cnt != 8'h00) && tx_valid && (tx_data != cmp_byte || tx_is_addr);
  // (RULE3) Buffered push side
  always_comb begin
    fif.push_valid = 1'b0;
    fif.push_data = {1'b0, tx_data};
    tx_ready = 1'b0;
    if (reverse) begin
      // (RULE12) Busy low marks a command byte
      fif.push_valid = rev_take;
      fif.push_data = {!s_busy, s_pdata};
    end else if (push_cnt) begin
      // (RULE7) Count byte first
      fif.push_valid = 1'b1;
      fif.push_data = {1'b1, 1'b0, cmp_cnt[6:0]};
    end else if (COMPRESS_EN && compress && ecp_en && cmp_have && tx_valid && tx_is_addr) begin
      // The pending run byte leaves before an address, so order is kept.
      fif.push_valid = 1'b1;
      fif.push_data = {1'b0, cmp_byte};
    end else if (COMPRESS_EN && compress && ecp_en && !tx_is_addr) begin
      tx_ready = 1'b1;
      fif.push_valid = cmp_have && tx_valid && tx_data != cmp_byte;
      fif.push_data = {1'b0, cmp_byte};
      if (!fif.push_ready) tx_ready = 1'b0;
    end else begin
      fif.push_valid = tx_valid;
      fif.push_data = {ecp_en & tx_is_addr, tx_data};
      tx_ready = fif.push_ready;
    end
  end
  // Compression run tracking; the pending byte leaves when a different byte arrives.
  always_comb begin
    next_cmp_byte = cmp_byte;
    next_cmp_cnt = cmp_cnt;
    next_cmp_have = cmp_have;
    if (!(COMPRESS_EN && compress && ecp_en) || reverse) begin
      next_cmp_have = 1'b0;
      next_cmp_cnt = 8'h00;
    end else if (push_cnt) begin
      if (fif.push_ready) next_cmp_cnt = 8'h00;
    end else if (cmp_have && tx_valid && tx_is_addr) begin
      if (fif.push_ready) next_cmp_have = 1'b0;
    end else if (tx_valid && !tx_is_addr && tx_ready) begin
      if (cmp_have && tx_data == cmp_byte && cmp_cnt != 8'h7f) begin
        next_cmp_cnt = cmp_cnt + 8'h01;
      end else begin
        next_cmp_byte = tx_data;
        next_cmp_cnt = 8'h00;
        next_cmp_have = 1'b1;
      end
    end
  end
  // Reverse pop side with run-length expansion toward the user.
  always_comb begin
    fif.pop_ready = 1'b0;
    fif.flush = (next_reverse != reverse);
    next_run_cnt = run_cnt;
    next_run_pend = run_pend;
    next_rx_reg = rx_reg;
    next_rx_cmd_reg = rx_cmd_reg;
    next_rx_full = rx_full && !rx_ready;
    if (reverse && (!rx_full || rx_ready) && fif.pop_valid) begin
      if (fif.pop_data[8] && !fif.pop_data[CMD_ADDR_BIT]) begin
        // (RULE6) Capture the count
        fif.pop_ready = 1'b1;
        next_run_cnt = {1'b0, fif.pop_data[6:0]};
        next_run_pend = 1'b1;
      end else begin
        // (RULE5) Hardware expansion
        next_rx_reg = fif.pop_data[7:0];
        next_rx_cmd_reg = fif.pop_data[8];
        next_rx_full = 1'b1;
        if (run_pend && !fif.pop_data[8] && run_cnt != 8'h00) begin
          next_run_cnt = run_cnt - 8'h01;
        end else begin
          fif.pop_ready = 1'b1;
          next_run_pend = 1'b0;
        end
      end
    end
    if (!reverse) begin
      fif.pop_ready = (state == ECPP_IDLE) && fif.pop_valid;
    end
  end
  assign rx_valid = rx_full;
  assign rx_data = rx_reg;
  assign rx_is_cmd = rx_cmd_reg;
  // Cable sequencer for forward, legacy and reverse handshakes.
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    next_reverse = reverse;
    next_pd_reg = pd_reg;
    next_strobe_reg = strobe_reg;
    next_afd_reg = afd_reg;
    case (state)
      ECPP_IDLE: begin
        next_strobe_reg = 1'b1;
        if (want_rev != reverse && fif.empty) begin
          next_state = ECPP_TURN;
          next_reverse = want_rev;
        end else if (!reverse && fif.pop_valid) begin
          // (RULE9) Phase-dependent byte
          next_pd_reg = fif.pop_data[7:0];
          // (RULE16) Command marker
          next_afd_reg = ecp_en ? !fif.pop_data[8] : 1'b1;
          next_tcnt = CNT_W'(SETUP_CYC);
          next_state = ECPP_SETUP;
        end else if (reverse) begin
          next_state = ECPP_REV_REQ;
        end
      end
      ECPP_SETUP: begin
        if (tcnt > CNT_W'(1)) next_tcnt = tcnt - 1'b1;
        // (RULE8) Strobe waits for busy low
        else if (!s_busy) begin
          next_strobe_reg = 1'b0;
          next_tcnt = CNT_W'(STROBE_CYC);
          next_state = ECPP_STROBE;
        end
      end
      ECPP_STROBE: begin
        // (RULE4) Automatic legacy strobe
        if (!ecp_en) begin
          if (tcnt > CNT_W'(1)) next_tcnt = tcnt - 1'b1;
          else next_state = ECPP_WAIT_BUSY;
        end else if (s_busy) begin
          next_state = ECPP_WAIT_BUSY;
        end
      end
      ECPP_WAIT_BUSY: begin
        next_strobe_reg = 1'b1;
        // (RULE11) Busy low frees the lines
        if (!s_busy || !ecp_en) begin
          // Host acknowledge returns high between bytes, so a turn toward reverse never sees it rise.
          next_afd_reg = 1'b1;
          next_state = ECPP_IDLE;
        end
      end
      ECPP_TURN: begin
        // Host acknowledge rises only once init has gone high again.
        next_afd_reg = 1'b1;
        // (RULE14) Wait for direction acknowledge
        if (dir_ack) next_state = ECPP_IDLE;
      end
      ECPP_REV_REQ: begin
        next_afd_reg = 1'b0;
        if (want_rev != reverse) begin
          next_state = ECPP_IDLE;
        // (RULE15) Request a reverse byte
        end else if (rev_take) begin
          next_state = ECPP_REV_ACK;
        end
      end
      ECPP_REV_ACK: begin
        // (RULE10) Interlock with peripheral clock
        next_afd_reg = 1'b1;
        if (s_ack_n) next_state = ECPP_REV_REQ;
      end
      default: next_state = ECPP_IDLE;
    endcase
  end
  // (RULE12) Busy-level command marking is applied at the push above.
  // (RULE1) Legacy mode keeps host acknowledge high and drives data outward.
  assign pdata_out = pd_reg;
  assign pdata_oe_n = reverse || (state == ECPP_TURN);
  assign strobe_n = strobe_reg;
  assign autofd_n = afd_reg;
  // (RULE17) Forward-only fault event
  assign fault_event = !s_fault_n && fault_d && !reverse;
  // Every register of the engine; reset returns the cable to forward idle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ECPP_IDLE;
      tcnt <= '0;
      reverse <= 1'b0;
      pd_reg <= 8'h00;
      strobe_reg <= 1'b1;
      afd_reg <= 1'b1;
      run_cnt <= 8'h00;
      run_pend <= 1'b0;
      cmp_byte <= 8'h00;
      cmp_cnt <= 8'h00;
      cmp_have <= 1'b0;
      rx_reg <= 8'h00;
      rx_cmd_reg <= 1'b0;
      rx_full <= 1'b0;
      fault_d <= 1'b1;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      reverse <= next_reverse;
      pd_reg <= next_pd_reg;
      strobe_reg <= next_strobe_reg;
      afd_reg <= next_afd_reg;
      run_cnt <= next_run_cnt;
      run_pend <= next_run_pend;
      cmp_byte <= next_cmp_byte;
      cmp_cnt <= next_cmp_cnt;
      cmp_have <= next_cmp_have;
      rx_reg <= next_rx_reg;
      rx_cmd_reg <= next_rx_cmd_reg;
      rx_full <= next_rx_full;
      fault_d <= s_fault_n;
    end
  end
endmodule

// [ecpp_port_chk.sv]
/*
  Checker of the port engine's cable handshakes, bound to ecpp_port.
  Assumes one core_clk domain and the synchronous reset of the port.
*/
`timescale 1ns/10ps
module ecpp_chk
  import ecpp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ecp_en,
  input wire logic dir_reverse,
  input wire logic tx_ready,
  input wire logic fifo_full,
  input wire logic dir_ack,
  input wire logic fault_event,
  input wire logic online,
  input wire logic [7:0] pdata_out,
  input wire logic pdata_oe_n,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic init_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic select
);
  logic [7:0] prev_pd;
  logic [7:0] stable_cnt;
  logic [7:0] low_cnt;
  // Saturating hold counters, so a long idle never wraps into a false short setup.
  always_ff @(posedge core_clk) begin
    prev_pd <= pdata_out;
    if (reset || pdata_out != prev_pd) stable_cnt <= 8'h00;
    else if (stable_cnt != 8'hff) stable_cnt <= stable_cnt + 8'h01;
    if (reset || strobe_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_strobe_setup: assert property ($fell(strobe_n) |-> stable_cnt >= SETUP_CYC - 2)
    else $error("strobe fell before data setup");
  a_strobe_idle: assert property ($fell(strobe_n) |-> !busy && !$past(busy, 2))
    else $error("strobe fell while peripheral busy");
  a_legacy_width: assert property ($rose(strobe_n) && !ecp_en |-> low_cnt >= STROBE_CYC - 1)
    else $error("legacy strobe too short");
  a_ecp_interlock: assert property ($rose(strobe_n) && ecp_en |-> busy)
    else $error("strobe released before busy");
  a_full_refuse: assert property (fifo_full |-> !tx_ready)
    else $error("byte accepted while buffer full");
  a_rev_release: assert property (!init_n |-> pdata_oe_n)
    else $error("host drives data lines in reverse");
  a_rev_select: assert property ($fell(init_n) |-> $past(ecp_en && dir_reverse))
    else $error("reverse entered without request");
  a_rev_request: assert property ($fell(autofd_n) && !init_n |-> dir_ack)
    else $error("byte requested before direction acknowledge");
  a_rev_interlock: assert property ($rose(autofd_n) && !init_n |-> !ack_n)
    else $error("host acknowledge rose without peripheral clock");
  a_fault_pulse: assert property (fault_event |-> init_n ##1 !fault_event)
    else $error("fault event outside forward or too long");
  a_online_follow: assert property ($rose(select) |-> ##[1:4] online)
    else $error("online does not follow select");
endmodule
bind ecpp_port ecpp_chk u_ecpp_chk (.core_clk, .reset, .ecp_en, .dir_reverse, .tx_ready,
  .fifo_full, .dir_ack, .fault_event, .online, .pdata_out, .pdata_oe_n, .strobe_n, .autofd_n,
  .init_n, .ack_n, .busy, .select);

// [ecpp_periph.sv]
/*
  Behavioural peripheral at the cable end of the port engine.
  Assumes the bench loads reverse entries {is_cmd, byte} into rq.
*/
`timescale 1ns/10ps
module ecpp_periph (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] lag,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic init_n,
  input wire logic [7:0] pd_host,
  output logic busy,
  output logic ack_n,
  output logic perror,
  output logic [7:0] pd_drv,
  output logic cap_v,
  output logic [8:0] cap
);
  logic [8:0] rq[$];
  logic [8:0] e;
  bit drv;
  // One loop answers on the edge after each change; the strobe latch and the reverse direction acknowledge wait lag cycles more.
  initial begin
    {busy, ack_n, perror, cap_v, pd_drv, cap} = {3'b011, 1'b0, 8'h00, 9'h000};
    drv = 0;
    forever begin
      @(posedge core_clk);
      cap_v <= 1'b0;
      if (reset) begin
        {busy, ack_n, perror} <= 3'b011;
        drv = 0;
      end else if (init_n) begin
        // Forward idle with the direction line high.
        {ack_n, perror} <= 2'b11;
        drv = 0;
        // Latch byte and command flag, then interlock on the strobe.
        if (!strobe_n && !busy) begin
          repeat (lag) @(posedge core_clk);
          cap <= {!autofd_n, pd_host};
          cap_v <= 1'b1;
          busy <= 1'b1;
        end else if (strobe_n && busy) begin
          busy <= 1'b0;
        end
      end else if (perror) begin
        repeat (lag) @(posedge core_clk);
        perror <= 1'b0;
      end else if (!autofd_n && ack_n && rq.size() > 0) begin
        // Present the byte, busy high for data, then clock it.
        e = rq.pop_front();
        pd_drv <= e[7:0];
        busy <= !e[8];
        drv = 1;
        @(posedge core_clk);
        ack_n <= 1'b0;
      end else if (autofd_n && !ack_n) begin
        ack_n <= 1'b1;
        drv = 0;
      end
      // Released lines toggle so a stale byte never passes for data.
      if (!drv) pd_drv <= ~pd_drv;
    end
  end
endmodule

// [ecp_parallel_port_tb.sv]
/*
  Self-checking bench of the port engine with a peripheral model.
  Assumes ecpp_port, ecpp_periph and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module ecp_parallel_port_tb;
  import ecpp_pkg::*;
  logic core_clk = 1'b0;
  logic reset, ecp_en, dir_reverse, compress, tx_valid, tx_is_addr, rx_ready, select, fault_n;
  logic tx_ready, rx_valid, rx_is_cmd, fifo_full, fifo_empty, dir_ack, fault_event;
  logic reverse_hint, online, dma_req, pdata_oe_n, strobe_n, autofd_n, init_n, select_in_n;
  logic ack_n, busy, perror, cap_v, rx_slow, saw_full;
  logic [1:0] lag;
  logic [7:0] tx_data, rx_data, pdata_out, pd_drv, pdata_in, d;
  logic [8:0] cap;
  logic [8:0] fq[$];
  logic [8:0] rxq[$];
  int miscompares = 0, checks_done = 0, cyc = 0, i;
  integer seed = 32'h670f;
  always #10 core_clk = ~core_clk;
  // The engine's byte wins while it drives, otherwise the peripheral's.
  assign pdata_in = pdata_oe_n ? pd_drv : pdata_out;
  ecpp_port u_ecpp_port (.core_clk, .reset, .ecp_en, .dir_reverse, .compress, .tx_valid,
    .tx_ready, .tx_data, .tx_is_addr, .rx_valid, .rx_ready, .rx_data, .rx_is_cmd, .fifo_full,
    .fifo_empty, .dir_ack, .fault_event, .reverse_hint, .online, .dma_req, .pd_in(1'b0),
    .pdata_in, .pdata_out, .pdata_oe_n, .strobe_n, .autofd_n, .init_n, .select_in_n, .ack_n,
    .busy, .perror, .select, .fault_n);
  ecpp_periph u_ecpp_periph (.core_clk, .reset, .lag, .strobe_n, .autofd_n, .init_n,
    .pd_host(pdata_out), .busy, .ack_n, .perror, .pd_drv, .cap_v, .cap);
  task chk(input logic [8:0] seen, input logic [8:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task conclude;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Holds the byte from a falling edge until a rising edge sees tx_ready.
  task send(input logic c, input logic [7:0] v);
    tx_valid = 1'b1;
    tx_is_addr = c;
    tx_data = v;
    #1;
    while (tx_ready !== 1'b1) begin
      @(negedge core_clk);
      #1;
    end
    @(negedge core_clk);
  endtask
  task drain;
    for (int k = 0; k < 4000 && (fq.size() || rxq.size() || !fifo_empty || !strobe_n); k++)
      @(negedge core_clk);
  endtask
  task run(input int n, input logic [7:0] v, input logic [7:0] a);
    fq.push_back({1'b1, 8'(n - 1)});
    fq.push_back({1'b0, v});
    fq.push_back({1'b1, a});
    repeat (n) send(1'b0, v);
    send(1'b1, a);
  endtask
  // Watcher: randomly stalls the reverse stream and compares each result with the oldest note.
  always @(negedge core_clk) begin
    rx_ready = rx_slow ? 1'($random(seed)) : 1'b1;
    if (fifo_full === 1'b1) saw_full = 1'b1;
    if (rx_valid === 1'b1 && rx_ready) chk({rx_is_cmd, rx_data}, rxq.size() ? rxq.pop_front() : 9'h1ff);
    if (cap_v === 1'b1) chk(cap, fq.size() ? fq.pop_front() : 9'h1ff);
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    {reset, ecp_en, dir_reverse, compress, tx_valid, tx_is_addr, rx_slow, saw_full} = 8'h80;
    {select, fault_n, lag, tx_data, rx_ready} = {2'b01, 2'b00, 8'h00, 1'b1};
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    chk({5'h00, select_in_n, strobe_n, autofd_n, init_n}, 9'h007);
    chk({8'h00, fifo_empty}, 9'h001);
    chk({8'h00, dma_req}, 9'h001);
    $display("test reset done");
    // Legacy bytes are strobed out by the engine itself.
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      fq.push_back({1'b0, d});
      send(1'b0, d);
    end
    tx_valid = 1'b0;
    drain;
    $display("test legacy done");
    // Back-to-back extended bytes with a slow peripheral fill the buffer.
    ecp_en = 1'b1;
    lag = 2'd3;
    for (i = 0; i < 20; i++) begin
      d = 8'($random(seed)) | ((i % 5 == 0) ? 8'h80 : 8'h00);
      fq.push_back({i % 5 == 0, d});
      send(i % 5 == 0, d);
    end
    tx_valid = 1'b0;
    drain;
    chk({8'h00, saw_full}, 9'h001);
    $display("test forward done");
    // Runs of equal bytes leave as count then byte.
    lag = 2'd0;
    compress = 1'b1;
    run(5, 8'h41, 8'h85);
    run(2, 8'h7e, 8'h86);
    tx_valid = 1'b0;
    drain;
    compress = 1'b0;
    $display("test compress done");
    fault_n = 1'b0;
    for (i = 0; i < 10 && fault_event !== 1'b1; i++) @(negedge core_clk);
    chk({8'h00, fault_event}, 9'h001);
    chk({8'h00, reverse_hint}, 9'h001);
    fault_n = 1'b1;
    $display("test fault done");
    // Reverse burst with a count command, a late peer and a stalling user.
    u_ecpp_periph.rq = '{9'h011, 9'h102, 9'h05a, 9'h183};
    rxq = '{9'h011, 9'h05a, 9'h05a, 9'h05a, 9'h183};
    {rx_slow, lag, dir_reverse} = 4'b1101;
    drain;
    chk({8'h00, init_n}, 9'h000);
    chk({8'h00, dir_ack}, 9'h001);
    chk({8'h00, dma_req}, 9'h000);
    chk({8'h00, pdata_oe_n}, 9'h001);
    {rx_slow, dir_reverse} = 2'b00;
    for (i = 0; i < 200 && init_n !== 1'b1; i++) @(negedge core_clk);
    chk({8'h00, init_n}, 9'h001);
    fq.push_back(9'h0a5);
    send(1'b0, 8'ha5);
    tx_valid = 1'b0;
    drain;
    $display("test reverse done");
    select = 1'b1;
    repeat (5) @(negedge core_clk);
    chk({8'h00, online}, 9'h001);
    $display("test select done");
    conclude;
  end
endmodule
